// *** bape_pkg.sv ***
// Constants and carrier types for the branch address packet encoder.
// Assumes one core clock; all event inputs come from logic on that clock.
package bape_pkg;

    // Address and packet geometry
    localparam int         ADDR_W          = 32;
    localparam int         VAL_W           = 35;
    localparam int         GRP_W           = 7;
    localparam logic [2:0] MAX_BYTES       = 3'h5;
    localparam logic [2:0] SYNC_BYTES      = 3'h5;
    localparam int         FIFO_DEPTH      = 8;
    localparam int         BYTE_W          = 8;

    // Field positions inside a packet byte
    localparam int         CONT_BIT        = 7;
    localparam int         EBIT_POS        = 6;

    // Sync packet header: reason code at [6:5], rest zero
    localparam int         SYNC_RSN_LSB    = 5;
    localparam logic [7:0] SYNC_HDR_BASE   = 8'h00;

    // Reset values
    localparam logic [31:0] REF_RST        = 32'h0000_0000;
    localparam logic [31:0] ABORT_VEC_DEF  = 32'h0000_0010;

    // Pipeline status codes driven on the status bus
    localparam logic [2:0] PS_EXEC         = 3'h0;
    localparam logic [2:0] PS_EXEC_BRANCH  = 3'h1;
    localparam logic [2:0] PS_WAIT         = 3'h2;
    localparam logic [2:0] PS_WAIT_DATA    = 3'h3;
    localparam logic [2:0] PS_DISABLED     = 3'h7;

    // One core cycle of trace events
    typedef struct packed {
        logic        inst_exec;
        logic        inst_traced;
        logic        br_valid;
        logic [31:0] br_target;
        logic        br_hw;
        logic        exc_cancel;
        logic        abort;
        logic        abort_imprecise;
        logic        data_valid;
        logic [7:0]  data_byte;
        logic        sync_req;
        logic [1:0]  sync_reason;
        logic [31:0] sync_addr;
        logic        sync_hw;
        logic        icmp_hit;
        logic        dcmp_hit;
    } bape_evt_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_SYNC,
        ST_DATA,
        ST_BRANCH
    } bape_state_t;

endpackage

// *** bape_encoder.sv ***
// Branch address packet encoder with its output byte FIFO.
// Assumes the core holds an event until o_evt_ready and the trace port
// drains bytes with a valid/ready handshake on the same clock.
//
// Summary of operation
// - Compress target against last emitted branch, or sync address if sent
// - Full address takes exactly five bytes
// - Overwrite only sent low bits of reference
// - Branch bytes pushed last each cycle
// - Continuation bit set except final byte
// - Indirect branch traced even if target untraced
// - Branch without execution signals wait-with-data
// - Marker one placed above address
// - Shift two word-aligned, one halfword-aligned
// - Append one as branch identifier bit
// - Split value into seven-bit groups
// - Fifth byte follows fixed per-state pattern
// - Exception-cancel flag in word-state fifth byte
// - Halfword state never carries cancel flag
// - Data abort adds branch to abort vector
// - Data traced regardless of abort
// - Precise abort leaves cancel flag clear
// - Imprecise abort sets cancel flag
// - Imprecise abort blocks exact instruction match
// - No reason code in branch packets
// - Packet length readable from bytes alone
// - Sync address four raw bytes, bit0 state
`timescale 1ns/1ps
`default_nettype none

module bape_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input  wire logic             i_ref_clk,
    input  wire logic             i_rst_n,
    // Fill side
    input  wire logic             i_in_valid,
    input  wire logic [WIDTH-1:0] i_in_data,
    output logic                  o_in_ready,
    // Drain side
    output logic                  o_out_valid,
    output logic      [WIDTH-1:0] o_out_data,
    input  wire logic             i_out_ready
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr_r;
    logic [AW-1:0]    rd_ptr_r;
    logic [AW:0]      count_r;
    logic             push;
    logic             pop;

    // Full and empty come straight from the occupancy count
    assign o_in_ready  = (count_r != (AW+1)'(DEPTH));
    assign o_out_valid = (count_r != '0);
    assign o_out_data  = mem[rd_ptr_r];
    assign push        = i_in_valid & o_in_ready;
    assign pop         = o_out_valid & i_out_ready;

    // Storage write, no reset needed on the data array
    always_ff @(posedge i_ref_clk) begin
        if (push) begin
            mem[wr_ptr_r] <= i_in_data;
        end
    end

    // Pointers wrap at DEPTH, which need not be a power of two
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
        end else begin
            if (push) begin
                wr_ptr_r <= (wr_ptr_r == AW'(DEPTH-1)) ? '0 : wr_ptr_r + 1'b1;
            end
            if (pop) begin
                rd_ptr_r <= (rd_ptr_r == AW'(DEPTH-1)) ? '0 : rd_ptr_r + 1'b1;
            end
        end
    end

    // Occupancy
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            count_r <= '0;
        end else begin
            count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);

    a_fifo_no_overfill: assert property (
        count_r == (AW+1)'(DEPTH) |=> count_r <= (AW+1)'(DEPTH))
        else $error("fifo count exceeded depth");
endmodule

module bape_encoder
    import bape_pkg::*;
#(
    parameter logic [31:0] ABORT_VEC = ABORT_VEC_DEF,
    parameter int          DEPTH     = FIFO_DEPTH
) (
    // Clock and reset
    input  wire logic        i_ref_clk,
    input  wire logic        i_rst_n,
    // Core event port
    input  wire logic        i_trace_gate,
    input  wire logic        i_evt_valid,
    input  wire bape_evt_t   i_evt,
    output logic             o_evt_ready,
    // Status and comparator qualification
    output logic       [2:0] o_pipeline_status_bus,
    output logic             o_icmp_exact,
    output logic             o_dcmp_exact,
    output logic      [31:0] o_ref_addr,
    // Packet byte stream toward the trace port
    output logic             o_pkt_valid,
    output logic       [7:0] o_pkt_byte,
    input  wire logic        i_pkt_ready
);
    // Reset release through two flops
    logic rst_s1_r;
    logic rst_n_r;
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rst_s1_r <= 1'b0;
            rst_n_r  <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_n_r  <= rst_s1_r;
        end
    end

    // Encoded value: marker and identifier bit laid out per state
    function automatic logic [VAL_W-1:0] pack_val(
        input logic [31:0] a, input logic hw, input logic e);
        logic [VAL_W-1:0] v;
        v = '0;
        if (hw) begin
            v = {2'b00, 1'b1, a[31:1], 1'b1};
        end else begin
            v = {e, 2'b00, 1'b1, a[31:2], 1'b1};
        end
        return v;
    endfunction

    // Bytes needed to cover the highest changed address bit
    function automatic logic [2:0] need_bytes(
        input logic [31:0] a, input logic [31:0] base, input logic hw,
        input logic force_full);
        logic [31:0] diff;
        int          n;
        diff = a ^ base;
        n    = 1;
        for (int i = 1; i < ADDR_W; i++) begin
            if (diff[i] && (hw || i >= 2)) begin
                n = (hw ? i : i - 1) / GRP_W + 1;
            end
        end
        if (force_full || n > 5) begin
            n = 5;
        end
        return 3'(n);
    endfunction

    // Address bits actually carried by an n-byte packet
    function automatic logic [31:0] sent_mask(input logic [2:0] n,
                                              input logic hw);
        logic [31:0] m;
        int          lim;
        m   = '0;
        lim = GRP_W * int'(n);
        for (int i = 0; i < ADDR_W; i++) begin
            m[i] = (n == MAX_BYTES) || (hw ? (i < lim) : (i <= lim));
        end
        return m;
    endfunction

    bape_state_t       state_r;
    bape_evt_t         ev_r;
    logic [2:0]        idx_r;
    logic [2:0]        nbytes_r;
    logic [VAL_W-1:0]  val_r;
    logic              do_data_r;
    logic              do_br_r;
    logic [31:0]       ref_r;
    logic              ref_hw_r;

    logic              accept;
    logic              fifo_ready;
    logic              push;
    logic [7:0]        push_byte;
    logic              last_byte;

    // Branch decision and compression inputs for the incoming event
    logic              need_br;
    logic [31:0]       br_addr;
    logic              br_hw;
    logic              br_e;
    logic [31:0]       base_addr;
    logic              base_hw;
    logic [2:0]        br_n;
    logic [31:0]       br_mask;
    logic              traced;

    assign o_evt_ready = (state_r == ST_IDLE) && rst_n_r;
    assign accept      = i_evt_valid && o_evt_ready;
    assign traced      = i_trace_gate || i_evt.inst_traced;

    // Abort overrides any other target: vector taken in word state
    always_comb begin
        need_br = i_evt.abort ||
                  (i_evt.inst_traced && i_evt.br_valid);
        br_addr = i_evt.abort ? ABORT_VEC : i_evt.br_target;
        br_hw   = i_evt.abort ? 1'b0 : i_evt.br_hw;
        if (i_evt.abort) begin
            br_e = i_evt.abort_imprecise;
        end else begin
            br_e = i_evt.exc_cancel && !i_evt.br_hw;
        end
        // Only a sync that is really sent moves the reference first;
        // a gated-off sync must not disturb the receiver's copy
        base_addr = (i_evt.sync_req && i_trace_gate) ? i_evt.sync_addr
                                                     : ref_r;
        base_hw   = (i_evt.sync_req && i_trace_gate) ? i_evt.sync_hw
                                                     : ref_hw_r;
        br_n      = need_bytes(br_addr, base_addr, br_hw,
                               br_e || (br_hw != base_hw));
        br_mask   = sent_mask(br_n, br_hw);
    end

    // Sequencer: sync packet, then data, then branch bytes last
    always_ff @(posedge i_ref_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            state_r <= ST_IDLE;
            idx_r   <= 3'h0;
        end else if (accept) begin
            idx_r <= 3'h0;
            if (i_evt.sync_req && i_trace_gate) begin
                state_r <= ST_SYNC;
            end else if (i_evt.data_valid && traced) begin
                state_r <= ST_DATA;
            end else if (need_br) begin
                state_r <= ST_BRANCH;
            end
        end else if (push) begin
            idx_r <= idx_r + 3'h1;
            unique case (state_r)
                ST_SYNC: begin
                    if (idx_r == SYNC_BYTES - 3'h1) begin
                        idx_r   <= 3'h0;
                        state_r <= do_data_r ? ST_DATA :
                                   do_br_r   ? ST_BRANCH : ST_IDLE;
                    end
                end
                ST_DATA: begin
                    idx_r   <= 3'h0;
                    state_r <= do_br_r ? ST_BRANCH : ST_IDLE;
                end
                ST_BRANCH: begin
                    if (last_byte) begin
                        state_r <= ST_IDLE;
                    end
                end
                ST_IDLE: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

    // Event capture; data kept whatever the abort status
    always_ff @(posedge i_ref_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            ev_r      <= '0;
            nbytes_r  <= 3'h1;
            val_r     <= '0;
            do_data_r <= 1'b0;
            do_br_r   <= 1'b0;
        end else if (accept) begin
            ev_r      <= i_evt;
            nbytes_r  <= br_n;
            val_r     <= pack_val(br_addr, br_hw, br_e);
            do_data_r <= i_evt.data_valid && traced;
            do_br_r   <= need_br;
        end
    end

    // Reference: sync reload, then merge of the bits sent
    always_ff @(posedge i_ref_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            ref_r    <= REF_RST;
            ref_hw_r <= 1'b0;
        end else if (accept) begin
            if (need_br) begin
                ref_r    <= (base_addr & ~br_mask) |
                            (br_addr & br_mask);
                ref_hw_r <= br_hw;
            end else if (i_evt.sync_req && i_trace_gate) begin
                ref_r    <= i_evt.sync_addr;
                ref_hw_r <= i_evt.sync_hw;
            end
        end
    end

    // Output byte formation
    always_comb begin
        push_byte = 8'h00;
        last_byte = 1'b0;
        unique case (state_r)
            ST_SYNC: begin
                if (idx_r == 3'h0) begin
                    push_byte = SYNC_HDR_BASE |
                        (8'(ev_r.sync_reason) << SYNC_RSN_LSB);
                end else begin
                    // Four raw little-endian bytes, bit 0 is the state
                    push_byte = 8'(ev_r.sync_addr >> (8 * (idx_r - 3'h1)));
                    if (idx_r == 3'h1) begin
                        push_byte[0] = ev_r.sync_hw;
                    end
                end
            end
            ST_DATA: push_byte = ev_r.data_byte;
            ST_BRANCH: begin
                // Header is the address itself, never a reason code;
                // the fifth group is the top seven bits and ends the packet
                last_byte = (idx_r == nbytes_r - 3'h1);
                push_byte[GRP_W-1:0] =
                    7'(val_r >> (GRP_W * int'(idx_r)));
                push_byte[CONT_BIT] = !last_byte;
            end
            ST_IDLE: push_byte = 8'h00;
        endcase
    end

    assign push = (state_r != ST_IDLE) && fifo_ready;

    // Pipeline status per accepted cycle, else wait, or disabled once idle and drained with the gate off
    always_ff @(posedge i_ref_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            o_pipeline_status_bus <= PS_DISABLED;
        end else if (accept) begin
            if (i_evt.inst_exec) begin
                o_pipeline_status_bus <= need_br ? PS_EXEC_BRANCH : PS_EXEC;
            end else if (need_br) begin
                o_pipeline_status_bus <= PS_WAIT_DATA;
            end else begin
                o_pipeline_status_bus <= PS_WAIT;
            end
        end else if (state_r == ST_IDLE && !o_pkt_valid) begin
            o_pipeline_status_bus <= i_trace_gate ? PS_WAIT : PS_DISABLED;
        end else begin
            o_pipeline_status_bus <= PS_WAIT;
        end
    end

    // Comparator qualification: imprecise abort cancels last instruction
    always_ff @(posedge i_ref_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            o_icmp_exact <= 1'b0;
            o_dcmp_exact <= 1'b0;
        end else if (accept) begin
            o_icmp_exact <= i_evt.icmp_hit &&
                !(i_evt.abort && i_evt.abort_imprecise);
            o_dcmp_exact <= i_evt.dcmp_hit;
        end
    end

    assign o_ref_addr = ref_r;

    // Byte FIFO; when it fills the sequencer and core both stall
    bape_fifo #(
        .WIDTH (BYTE_W),
        .DEPTH (DEPTH)
    ) u_fifo (
        .i_ref_clk   (i_ref_clk),
        .i_rst_n     (rst_n_r),
        .i_in_valid  (state_r != ST_IDLE),
        .i_in_data   (push_byte),
        .o_in_ready  (fifo_ready),
        .o_out_valid (o_pkt_valid),
        .o_out_data  (o_pkt_byte),
        .i_out_ready (i_pkt_ready)
    );

    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!rst_n_r);

    a_cont_bit_more: assert property (
        push && state_r == ST_BRANCH && push_byte[CONT_BIT]
        |=> state_r == ST_BRANCH)
        else $error("continuation set on final branch byte");

    a_branch_len_max: assert property (
        state_r == ST_BRANCH |-> idx_r < MAX_BYTES)
        else $error("branch packet longer than five bytes");

    a_branch_last_out: assert property (
        push && state_r == ST_BRANCH && last_byte |=> state_r == ST_IDLE)
        else $error("item pushed after branch bytes");

    a_fifth_byte_fmt: assert property (
        push && state_r == ST_BRANCH && idx_r == 3'h4 |->
        (push_byte[7:4] == 4'h1) ||
        (push_byte[7] == 1'b0 && push_byte[5:3] == 3'h1))
        else $error("reserved fifth byte pattern");

    a_wait_data_stat: assert property (
        accept && need_br && !i_evt.inst_exec
        |=> o_pipeline_status_bus == PS_WAIT_DATA)
        else $error("missing wait-with-data status");

    a_abort_branch_req: assert property (
        accept && i_evt.abort |=> do_br_r && val_r[30:1] == ABORT_VEC[31:2])
        else $error("abort without branch to vector");

    a_imprecise_ebit: assert property (
        accept && i_evt.abort
        |=> val_r[VAL_W-1] == $past(i_evt.abort_imprecise))
        else $error("cancel flag mismatch on abort");

    a_icmp_blocked: assert property (
        accept && i_evt.abort && i_evt.abort_imprecise |=> !o_icmp_exact)
        else $error("instruction match after imprecise abort");

    a_sync_reload: assert property (
        accept && i_evt.sync_req && i_trace_gate && !need_br
        |=> ref_r == $past(i_evt.sync_addr))
        else $error("reference not reloaded by sync");

    a_sync_len_five: assert property (
        push && state_r == ST_SYNC && idx_r == 3'h4 |=> state_r != ST_SYNC)
        else $error("sync address not four bytes");
endmodule

`default_nettype wire

// *** bape_sink.sv ***
// Capture-side model of the trace port: takes packet bytes into a queue.
// Assumes the encoder's clock and reset; i_mode sets how often it is ready.
`timescale 1ns/1ps
`default_nettype none

module bape_sink (
    // Clock and reset
    input  wire logic       i_ref_clk,
    input  wire logic       i_rst_n,
    // Byte stream and pacing
    input  wire logic       i_valid,
    input  wire logic [7:0] i_byte,
    input  wire logic [1:0] i_mode,
    output logic            o_ready
);
    logic [1:0] cnt_r;
    logic [7:0] q [$];

    // Mode 0 always ready, 1 one cycle in four, 2 stalled
    always @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt_r   <= 2'h0;
            o_ready <= 1'b0;
        end else begin
            if (i_valid && o_ready)
                q.push_back(i_byte); // Taken only on a handshake edge
            cnt_r   <= cnt_r + 2'h1;
            o_ready <= (i_mode == 2'h0) || (i_mode == 2'h1 && cnt_r == 2'h2);
        end
    end
endmodule

`default_nettype wire

// *** bape_encoder_tb.sv ***
// Self-checking bench for the branch address packet encoder.
// Assumes bape_pkg, bape_encoder and bape_sink are compiled first.
`timescale 1ns/1ps
`default_nettype none

module bape_encoder_tb
    import bape_pkg::*;
;
    // Flags: gate exec brv hw | exc abort imprecise data | sync hit - -
    typedef struct packed {
        logic [11:0] f;
        logic [31:0] tgt;
        logic [2:0]  len;
    } bape_row_t;

    localparam logic [31:0] VEC  = 32'h0000_0010;
    localparam int          NROW = 15;
    localparam bape_row_t   ROWS [NROW] = '{
        {12'hc08, 32'h1000_0000, 3'h0}, // Sync only
        {12'he04, 32'h1000_0040, 3'h1},
        {12'he00, 32'h1000_4000, 3'h2},
        {12'he00, 32'h1010_4000, 3'h3},
        {12'he00, 32'h1810_4000, 3'h4},
        {12'he00, 32'h9810_4000, 3'h5},
        {12'he00, 32'h9810_4000, 3'h1}, // Unchanged target
        {12'hf80, 32'h9810_4002, 3'h5}, // Halfword, cancel
        {12'hb00, 32'h9810_4006, 3'h1}, // No execute
        {12'he80, 32'h9810_4000, 3'h5}, // Cancel flag
        {12'he10, 32'h9810_4100, 3'h2}, // Data then branch
        {12'hc50, 32'h0000_0000, 3'h5}, // Precise abort
        {12'he64, 32'h2000_0000, 3'h5}, // Imprecise abort
        {12'h610, 32'h0000_0020, 3'h1}, // Gate off, traced
        {12'h608, 32'h0000_0060, 3'h1}  // Sync held back by gate
    };

    logic        clk;
    logic        rst_n;
    logic        gate;
    logic        evt_valid;
    bape_evt_t   evt;
    logic        evt_ready;
    logic [2:0]  ps;
    logic        icmp;
    logic        dcmp;
    logic [31:0] ref_a;
    logic        pkt_valid;
    logic [7:0]  pkt_byte;
    logic        pkt_ready;
    logic [1:0]  mode;
    logic [2:0]  ps_s;
    logic        ic_s;
    logic        dc_s;
    logic [7:0]  exp_q [$];
    int          n_mismatch;
    int          tests_run;

    bape_encoder #(.ABORT_VEC(VEC), .DEPTH(8)) dut (
        .i_ref_clk(clk), .i_rst_n(rst_n), .i_trace_gate(gate),
        .i_evt_valid(evt_valid), .i_evt(evt), .o_evt_ready(evt_ready),
        .o_pipeline_status_bus(ps), .o_icmp_exact(icmp),
        .o_dcmp_exact(dcmp), .o_ref_addr(ref_a), .o_pkt_valid(pkt_valid),
        .o_pkt_byte(pkt_byte), .i_pkt_ready(pkt_ready));

    bape_sink u_sink (
        .i_ref_clk(clk), .i_rst_n(rst_n), .i_valid(pkt_valid),
        .i_byte(pkt_byte), .i_mode(mode), .o_ready(pkt_ready));

    // 100 MHz core clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic chk(input string nm, input logic [31:0] ex,
                       input logic [31:0] got);
        tests_run++;
        if (got !== ex) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", nm, ex, got);
        end
    endtask

    // Offer one event, hold it until taken, sample what the accept set
    task automatic send(input bape_evt_t e, input logic g);
        int k;
        k = 0;
        @(posedge clk);
        evt_valid <= 1'b1;
        evt       <= e;
        gate      <= g;
        @(negedge clk);
        while (!evt_ready && k < 200) begin
            @(negedge clk);
            k++;
        end
        chk("accept", 32'h1, 32'(k < 200));
        @(posedge clk);
        evt_valid <= 1'b0;
        @(negedge clk);
        ps_s = ps;
        ic_s = icmp;
        dc_s = dcmp;
    endtask

    // Expected branch bytes, worked out independently of the design
    task automatic exp_br(input logic [31:0] a, input logic hw,
                          input logic e, input logic [2:0] len);
        logic [34:0] v;
        v = hw ? {3'h1, a[31:1], 1'b1} : {e, 3'h1, a[31:2], 1'b1};
        for (int k = 0; k < int'(len); k++)
            exp_q.push_back({k != int'(len) - 1, v[7*k +: 7]});
    endtask

    // Bounded wait for the bytes, then a short look for stray extras
    task automatic check_bytes();
        int k;
        k = 0;
        while (u_sink.q.size() < exp_q.size() && k < 300) begin
            @(posedge clk);
            k++;
        end
        repeat (6) @(posedge clk);
        chk("byte count", 32'(exp_q.size()), 32'(u_sink.q.size()));
        for (k = 0; k < exp_q.size() && k < u_sink.q.size(); k++)
            chk("pkt byte", 32'(exp_q[k]), 32'(u_sink.q[k]));
        exp_q.delete();
        u_sink.q.delete();
    endtask

    task automatic chk_reset();
        chk("evt ready", 32'h0, 32'(evt_ready));
        chk("pkt valid", 32'h0, 32'(pkt_valid));
        chk("status", 32'(PS_DISABLED), 32'(ps));
        chk("ref addr", REF_RST, ref_a);
    endtask

    task automatic final_report();
        $display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Run is well under a thousand cycles; this limit is far past it
    initial begin
        #200us;
        n_mismatch++;
        final_report();
    end

    // Table rows, then stall, then mid-run reset
    initial begin
        bape_evt_t e;
        bape_row_t r;
        n_mismatch = 0;
        tests_run  = 0;
        rst_n      = 1'b0;
        gate       = 1'b1;
        evt_valid  = 1'b0;
        evt        = '0;
        mode       = 2'h0;
        repeat (2) @(posedge clk);
        chk_reset();
        rst_n <= 1'b1;
        for (int i = 0; i < NROW; i++) begin
            r = ROWS[i];
            mode <= {1'b0, i[0]}; // Slow drain on odd rows
            e = '0;
            e.inst_exec       = r.f[10];
            e.inst_traced     = 1'b1;
            e.br_valid        = r.f[9];
            e.br_hw           = r.f[8];
            e.br_target       = r.tgt;
            e.exc_cancel      = r.f[7];
            e.abort           = r.f[6];
            e.abort_imprecise = r.f[5];
            e.data_valid      = r.f[4];
            e.data_byte       = 8'h5a;
            e.sync_req        = r.f[3];
            e.sync_reason     = 2'h1;
            e.sync_addr       = r.f[11] ? r.tgt : ~r.tgt; // Unsent: far off
            e.icmp_hit        = r.f[2];
            e.dcmp_hit        = r.f[2];
            if (r.f[3] && r.f[11]) begin
                exp_q.push_back(8'h20);
                for (int k = 0; k < 4; k++)
                    exp_q.push_back(r.tgt[8*k +: 8]);
            end
            if (r.f[4])
                exp_q.push_back(8'h5a);
            if (r.f[6])
                exp_br(VEC, 1'b0, r.f[5], r.len);
            else if (r.f[9])
                exp_br(r.tgt, r.f[8], r.f[7] & ~r.f[8], r.len);
            send(e, r.f[11]);
            chk("ref addr", r.f[6] ? VEC : r.tgt, ref_a);
            chk("icmp", 32'(r.f[2] & ~(r.f[6] & r.f[5])), 32'(ic_s));
            chk("dcmp", 32'(r.f[2]), 32'(dc_s));
            if (!r.f[10])
                chk("status", 32'(PS_WAIT_DATA), 32'(ps_s));
            check_bytes();
        end
        // Stalled port: FIFO fills, pushing stops, order survives
        mode <= 2'h2;
        e = '0;
        e.inst_exec   = 1'b1;
        e.inst_traced = 1'b1;
        e.br_valid    = 1'b1;
        e.exc_cancel  = 1'b1;
        e.br_target   = 32'h4000_0000;
        exp_br(32'h4000_0000, 1'b0, 1'b1, 3'h5);
        exp_br(32'h4000_0002, 1'b1, 1'b0, 3'h5);
        fork
            begin
                send(e, 1'b1);
                e.exc_cancel = 1'b0;
                e.br_hw      = 1'b1;
                e.br_target  = 32'h4000_0002;
                send(e, 1'b1);
            end
            begin
                repeat (40) @(negedge clk);
                chk("full ready", 32'h0, 32'(evt_ready));
                chk("full valid", 32'h1, 32'(pkt_valid));
                mode <= 2'h0;
            end
        join
        check_bytes();
        // Reset with bytes waiting: everything clears at once
        mode <= 2'h2;
        send(e, 1'b1);
        repeat (8) @(negedge clk);
        rst_n <= 1'b0;
        @(negedge clk);
        chk_reset();
        @(posedge clk);
        rst_n <= 1'b1;
        mode  <= 2'h0;
        repeat (4) @(negedge clk);
        chk("ready after reset", 32'h1, 32'(evt_ready));
        final_report();
    end
endmodule

`default_nettype wire
